// ==== hw/tcs_client_src.sv ====
// Client end: drives packets from a user request onto the stream.
`timescale 1ns/100ps
module tcs_client_src
	import tcs_pkg::*;
(
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                sys_rst,
	// Link readiness
	input  wire logic                lanes_stable,
	// Stream to MAC
	tcs_if.client                    link,
	// User side: one whole packet word by word, already buffered
	input  wire logic                usr_valid,
	input  wire logic [WORD_W-1:0]   usr_word,
	input  wire logic                usr_start,
	input  wire logic                usr_end,
	input  wire logic [UNUSED_W-1:0] usr_unused_bytes,
	input  wire logic                usr_corrupt,
	output logic                     usr_ready,
	output logic                     busy
);
	// Interface register: the word the MAC currently sees
	logic                q_reg;
	logic [WORD_W-1:0]   w_reg;
	logic                s_reg;
	logic                e_reg;
	logic [UNUSED_W-1:0] u_reg;
	logic                c_reg;
	// Skid slot behind it, filled when the MAC holds off
	logic                skid_valid_reg;
	logic                skid_valid_next;
	logic [WORD_W-1:0]   skid_word_reg;
	logic                skid_start_reg;
	logic                skid_end_reg;
	logic [UNUSED_W-1:0] skid_unused_reg;
	logic                skid_corrupt_reg;
	// Handshake and packet tracking
	logic                in_pkt_reg;
	logic                in_pkt_next;
	logic                load;
	logic                sent;
	logic                main_free;
	logic [UNUSED_W-1:0] usr_unused_kept;
	logic                usr_corrupt_kept;

	// Drive interface straight from registers
	assign link.client_tx_qualify = q_reg;
	assign link.client_tx_word = w_reg;
	assign link.client_tx_start = s_reg;
	assign link.client_tx_end = e_reg;
	assign link.client_tx_unused_bytes = u_reg;
	assign link.client_tx_corrupt_request = c_reg;
	// User handshake and MAC transfer
	assign load = usr_valid & usr_ready;
	assign sent = q_reg & link.mac_tx_accept;
	// Interface register is empty or empties at this edge
	assign main_free = ~q_reg | sent;
	// Skid fills when a user word arrives while the MAC holds off
	assign skid_valid_next = skid_valid_reg ? ~main_free : (load & ~main_free);
	assign in_pkt_next = load ? (in_pkt_reg | usr_start) & ~usr_end :
		in_pkt_reg;
	// Count and corrupt are zeroed off the end word
	assign usr_unused_kept  = usr_end ? usr_unused_bytes : '0;
	assign usr_corrupt_kept = usr_end & usr_corrupt;

	// Registered ready promises a free skid slot; new packets also wait
	// for stable lanes, seen one cycle late, so a drop may let one start by
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			usr_ready <= 1'b0;
		end else begin
			usr_ready <= ~skid_valid_next & (in_pkt_next | lanes_stable);
		end
	end

	// Qualify stays up while a word is parked or arriving
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q_reg <= 1'b0;
		end else if (main_free) begin
			q_reg <= skid_valid_reg | load;
		end
	end

	// Hold word and qualifiers unchanged until accepted
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			w_reg <= '0;
			s_reg <= 1'b0;
			e_reg <= 1'b0;
			u_reg <= '0;
			c_reg <= 1'b0;
		end else if (main_free & skid_valid_reg) begin
			w_reg <= skid_word_reg;
			s_reg <= skid_start_reg;
			e_reg <= skid_end_reg;
			u_reg <= skid_unused_reg;
			c_reg <= skid_corrupt_reg;
		end else if (main_free & load) begin
			w_reg <= usr_word;
			s_reg <= usr_start;
			e_reg <= usr_end;
			u_reg <= usr_unused_kept;
			c_reg <= usr_corrupt_kept;
		end
	end

	// Skid occupancy
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			skid_valid_reg <= 1'b0;
		end else begin
			skid_valid_reg <= skid_valid_next;
		end
	end

	// Skid contents; ready is low while full, so it never overwrites
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			skid_word_reg    <= '0;
			skid_start_reg   <= 1'b0;
			skid_end_reg     <= 1'b0;
			skid_unused_reg  <= '0;
			skid_corrupt_reg <= 1'b0;
		end else if (load & ~main_free) begin
			skid_word_reg    <= usr_word;
			skid_start_reg   <= usr_start;
			skid_end_reg     <= usr_end;
			skid_unused_reg  <= usr_unused_kept;
			skid_corrupt_reg <= usr_corrupt_kept;
		end
	end

	// Tracks being inside a packet for the lanes-stable gate
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			in_pkt_reg <= 1'b0;
			busy       <= 1'b0;
		end else begin
			in_pkt_reg <= in_pkt_next;
			busy       <= in_pkt_reg | q_reg | skid_valid_reg;
		end
	end
endmodule

// ==== hw/tcs_mac_sink.sv ====
// MAC end: accepts client words and hands them on, corrupting on request.
`timescale 1ns/100ps
module tcs_mac_sink
	import tcs_pkg::*;
(
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                sys_rst,
	// Stream from client
	tcs_if.mac                       link,
	// Downstream framing side
	input  wire logic                out_ready,
	output logic                     out_valid,
	output logic [WORD_W-1:0]        out_word,
	output logic                     out_start,
	output logic                     out_end,
	output logic [UNUSED_W-1:0]      out_unused_bytes,
	output logic                     out_corrupt,
	output logic [BLOCK_W-1:0]       out_error_block,
	output logic                     framing_error
);
	// Transfer and slot conditions
	logic                take;
	logic                out_load;
	logic                out_fill;
	logic                stall_in;
	// Accept and packet tracking state
	logic                accept_reg;
	logic                in_pkt_reg;
	// Skid slot: catches the word taken in the cycle the output stalls
	logic                skid_valid_reg;
	logic                skid_valid_next;
	logic [WORD_W-1:0]   skid_word_reg;
	logic                skid_start_reg;
	logic                skid_end_reg;
	logic [UNUSED_W-1:0] skid_unused_reg;
	logic                skid_corrupt_reg;
	// Incoming end-only fields after gating
	logic [UNUSED_W-1:0] in_unused;
	logic                in_corrupt;
	// Word chosen for the output register
	logic [WORD_W-1:0]   sel_word;
	logic                sel_start;
	logic                sel_end;
	logic [UNUSED_W-1:0] sel_unused;
	logic                sel_corrupt;

	// Zero accept lag: taken in the same cycle accept is high
	assign take = link.client_tx_qualify & accept_reg;
	assign link.mac_tx_accept = accept_reg;

	// Output slot is empty or empties at this edge
	assign out_load = ~out_valid | out_ready;
	// Something is waiting to enter the output slot
	assign out_fill = out_load & (skid_valid_reg | take);
	// A word taken while the output is stuck parks in the skid slot
	assign stall_in = take & ~out_load;
	// Skid empties as soon as the output slot frees up
	assign skid_valid_next = skid_valid_reg ? ~out_load : stall_in;

	// Count and corrupt only mean something on an end word
	assign in_unused = link.client_tx_end ?
		link.client_tx_unused_bytes : '0;
	assign in_corrupt = link.client_tx_end &
		link.client_tx_corrupt_request;

	// Parked word is older than the live one, so it always goes first
	assign sel_word    = skid_valid_reg ? skid_word_reg : link.client_tx_word;
	assign sel_start   = skid_valid_reg ? skid_start_reg : link.client_tx_start;
	assign sel_end     = skid_valid_reg ? skid_end_reg : link.client_tx_end;
	assign sel_unused  = skid_valid_reg ? skid_unused_reg : in_unused;
	assign sel_corrupt = skid_valid_reg ? skid_corrupt_reg : in_corrupt;

	// Registered accept can only promise a free skid slot; full rate is
	// kept because the skid absorbs the one word taken as the output stalls
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			accept_reg <= 1'b0;
		end else begin
			accept_reg <= ~skid_valid_next;
		end
	end

	// Skid occupancy
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			skid_valid_reg <= 1'b0;
		end else begin
			skid_valid_reg <= skid_valid_next;
		end
	end

	// Skid contents, loaded only when a taken word cannot move on
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			skid_word_reg    <= '0;
			skid_start_reg   <= 1'b0;
			skid_end_reg     <= 1'b0;
			skid_unused_reg  <= '0;
			skid_corrupt_reg <= 1'b0;
		end else if (stall_in) begin
			skid_word_reg    <= link.client_tx_word;
			skid_start_reg   <= link.client_tx_start;
			skid_end_reg     <= link.client_tx_end;
			skid_unused_reg  <= in_unused;
			skid_corrupt_reg <= in_corrupt;
		end
	end

	// Output valid: drops only when the slot drains with nothing behind it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			out_valid <= 1'b0;
		end else if (out_load) begin
			out_valid <= skid_valid_reg | take;
		end
	end

	// Output fields stand until downstream takes them
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			out_word         <= '0;
			out_start        <= 1'b0;
			out_end          <= 1'b0;
			out_unused_bytes <= '0;
			out_corrupt      <= 1'b0;
		end else if (out_fill) begin
			out_word         <= sel_word;
			out_start        <= sel_start;
			out_end          <= sel_end;
			out_unused_bytes <= sel_unused;
			out_corrupt      <= sel_corrupt;
		end
	end

	// Error block replaces the tail so the far receiver drops the frame
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			out_error_block <= '0;
		end else if (out_fill) begin
			out_error_block <= sel_corrupt ?
				TERMINATE_ERROR_BLOCK : '0;
		end
	end

	// Packet tracking; flags a gap, a stray or a nested start (sticky)
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			in_pkt_reg    <= 1'b0;
			framing_error <= 1'b0;
		end else begin
			if (take) begin
				in_pkt_reg <= (in_pkt_reg | link.client_tx_start) &
					~link.client_tx_end;
			end
			if ((take & ~in_pkt_reg & ~link.client_tx_start) |
				(take & in_pkt_reg & link.client_tx_start) |
				(in_pkt_reg & accept_reg & ~link.client_tx_qualify)) begin
				framing_error <= 1'b1;
			end
		end
	end
endmodule

// ==== pkg/tcs_if.sv ====
// Stream interface between the client source and the MAC sink.
`timescale 1ns/100ps
interface tcs_if
	import tcs_pkg::*;
(
	input wire logic clk
);
	logic [WORD_W-1:0]   client_tx_word;
	logic                client_tx_start;
	logic                client_tx_end;
	logic                client_tx_qualify;
	logic [UNUSED_W-1:0] client_tx_unused_bytes;
	logic                client_tx_corrupt_request;
	logic                mac_tx_accept;

	modport client (
		output client_tx_word, client_tx_start, client_tx_end,
		client_tx_qualify, client_tx_unused_bytes,
		client_tx_corrupt_request,
		input  mac_tx_accept, clk
	);
	modport mac (
		input  client_tx_word, client_tx_start, client_tx_end,
		client_tx_qualify, client_tx_unused_bytes,
		client_tx_corrupt_request, clk,
		output mac_tx_accept
	);
endinterface

// ==== pkg/tcs_pkg.sv ====
// Constants and types shared by both ends of the transmit client stream.
// What the stream rules require
// - Start marks first word, end marks last
// - First packet byte sits in top byte
// - Word and qualifiers count only when valid
// - Transfer when valid and accept share cycle
// - Source holds word steady while not accepted
// - 256-bit word, all sampled on clock
// - Source never sends frames under nine bytes; MIN_FRAME is not checked by the source
// - Packet words go in consecutive cycles
// - Valid stays high from start to end
// - Source buffers whole packet before starting; the source sends from the first word and holds at most two
// - Five-bit unused count on end word
// - Corrupt request on end word corrupts packet
// - Looped-back corrupted packet reads as malformed
// - Source waits for lanes stable after reset
// - Corruption replaces end with error block
// - Interface clock runs at 312.5 MHz
package tcs_pkg;
	localparam int WORD_W    = 256;
	localparam int UNUSED_W  = 5;
	localparam int BYTES_W   = WORD_W / 8;
	localparam int MIN_FRAME = 9;
	// Error block: sync header, block type, then eight error characters
	localparam logic [1:0]  ERR_SYNC = 2'h1;
	localparam logic [7:0]  ERR_TYPE = 8'h1E;
	localparam logic [6:0]  ERR_CHAR = 7'h1E;
	localparam int          BLOCK_W  = 66;
	localparam logic [BLOCK_W-1:0] TERMINATE_ERROR_BLOCK = {ERR_SYNC,
		ERR_TYPE, {8{ERR_CHAR}}};
	localparam int CLK_KHZ = 312500;
	typedef enum logic [1:0] {TCS_IDLE, TCS_LOAD, TCS_SEND} tcs_src_st_t;
endpackage

// ==== verification/tcs_stream_asserts.sv ====
// Checker watching the client stream between source and MAC sink.
`timescale 1ns/100ps
module tcs_stream_asserts
	import tcs_pkg::*;
(
	// Clock and reset
	input wire logic                clk,
	input wire logic                sys_rst,
	// Stream signals
	input wire logic [WORD_W-1:0]   client_tx_word,
	input wire logic                client_tx_start,
	input wire logic                client_tx_end,
	input wire logic                client_tx_qualify,
	input wire logic [UNUSED_W-1:0] client_tx_unused_bytes,
	input wire logic                client_tx_corrupt_request,
	input wire logic                mac_tx_accept
);
	// Short aliases keep all properties but p_qual and p_zero on one line
	wire qv = client_tx_qualify;
	wire acc = mac_tx_accept;
	wire eop = client_tx_end;
	logic in_pkt_reg;
	// Inside a packet once a non-end word is taken
	always_ff @(posedge clk)
		in_pkt_reg <= sys_rst ? 1'b0 : ((qv && acc) ? !eop : in_pkt_reg);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_hold; qv && !acc |=> qv && $stable(client_tx_word); endproperty
	a_hold: assert property (p_hold)
		else $error("word moved while stalled");
	property p_qual; qv && !acc |=> $stable(eop)
		&& $stable(client_tx_start); endproperty
	a_qual: assert property (p_qual)
		else $error("qualifier moved while stalled");
	property p_cont; qv && acc && !eop |=> qv; endproperty
	a_cont: assert property (p_cont)
		else $error("gap inside packet");
	property p_zero; qv && !eop |-> !client_tx_corrupt_request
		&& client_tx_unused_bytes == 5'h00; endproperty
	a_zero: assert property (p_zero)
		else $error("count or corrupt off end word");
	property p_rst; disable iff (1'b0) sys_rst |=> !qv && !acc; endproperty
	a_rst: assert property (p_rst)
		else $error("outputs active after reset");
	property p_up; $fell(sys_rst) |-> !acc ##1 acc; endproperty
	a_up: assert property (p_up)
		else $error("accept not raised after reset");
	property p_sop; qv && client_tx_start |-> !in_pkt_reg; endproperty
	a_sop: assert property (p_sop)
		else $error("start inside packet");
	property p_first; qv && !in_pkt_reg |-> client_tx_start; endproperty
	a_first: assert property (p_first)
		else $error("word outside packet without start");
endmodule

// ==== verification/tx_client_stream_sink_tb.sv ====
// Bench joining client source and MAC sink across the stream.
`timescale 1ns/100ps
module tx_client_stream_sink_tb import tcs_pkg::*;;
	localparam int BW = WORD_W + 8;
	logic sys_rst = 1'b1, lanes_stable = 1'b0, out_ready = 1'b1, clk;
	logic usr_valid = 1'b0, usr_start = 1'b0, usr_end = 1'b0;
	logic usr_corrupt = 1'b0, usr_ready, busy, out_valid, out_start;
	logic out_end, out_corrupt, framing_error;
	logic [WORD_W-1:0]   usr_word = '0, out_word;
	logic [UNUSED_W-1:0] usr_unused_bytes = 5'h00, out_unused_bytes;
	logic [BLOCK_W-1:0]  out_error_block;
	logic [BW-1:0]       exp_q[$];
	logic [BW-1:0]       exp_w;
	int                  miscompares = 0, checks = 0;
	tcs_if link_if (.clk(clk));
	tcs_client_src u_tcs_client_src (.clk, .sys_rst, .lanes_stable,
		.link(link_if.client), .usr_valid, .usr_word, .usr_start, .usr_end,
		.usr_unused_bytes, .usr_corrupt, .usr_ready, .busy);
	tcs_mac_sink u_tcs_mac_sink (.clk, .sys_rst, .link(link_if.mac),
		.out_ready, .out_valid, .out_word, .out_start, .out_end,
		.out_unused_bytes, .out_corrupt, .out_error_block, .framing_error);
	tcs_stream_asserts u_tcs_stream_asserts (.clk, .sys_rst,
		.client_tx_word(link_if.client_tx_word),
		.client_tx_start(link_if.client_tx_start),
		.client_tx_end(link_if.client_tx_end),
		.client_tx_qualify(link_if.client_tx_qualify),
		.client_tx_unused_bytes(link_if.client_tx_unused_bytes),
		.client_tx_corrupt_request(link_if.client_tx_corrupt_request),
		.mac_tx_accept(link_if.mac_tx_accept));
	// Clock at 100 MHz
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input logic [BW-1:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task complete_run;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// One user word, held until taken; expectation zeroes off-end fields
	task automatic send(input logic [7:0] b, input logic s, e, c,
		input logic [4:0] u);
		int n = 0;
		usr_valid <= 1'b1;
		usr_word <= {32{b}};
		usr_start <= s;
		usr_end <= e;
		usr_corrupt <= c;
		usr_unused_bytes <= u;
		do begin
			@(posedge clk);
			n++;
		end while (usr_ready !== 1'b1 && n < 40);
		if (usr_ready !== 1'b1) begin
			miscompares++;
			complete_run;
		end else begin
			exp_q.push_back({{32{b}}, s, e, e ? u : 5'h00, e & c});
		end
	endtask
	// Middle words carry junk count and corrupt to prove they are ignored
	task automatic packet(input int len, input logic c, input logic [4:0] u);
		for (int i = 0; i < len; i++)
			send(8'(len * 16 + i), i == 0, i == len - 1,
				i == len - 1 ? c : 1'b1, i == len - 1 ? u : 5'h0A);
	endtask
	task idle;
		usr_valid <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// Every word leaving the sink must match the next expectation
	always @(posedge clk)
		if (out_valid === 1'b1 && out_ready === 1'b1) begin
			exp_w = exp_q.size() ? exp_q.pop_front() : 'x;
			check({out_word, out_start, out_end, out_unused_bytes,
				out_corrupt}, exp_w);
			check(BW'(out_error_block), exp_w[0] ?
				BW'(TERMINATE_ERROR_BLOCK) : BW'(0));
		end
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		// Nine-byte start word held back until lanes settle
		fork
			packet(1, 1'b0, 5'h17);
			begin
				repeat (5) @(posedge clk);
				check(BW'(link_if.client_tx_qualify), BW'(0));
				lanes_stable <= 1'b1;
				@(posedge clk);
			end
		join
		idle;
		$display("lane gate test done");
		// Back-to-back packets, count at both extremes, one corrupted
		for (int p = 0; p < 3; p++)
			packet(p + 2, p == 2, p == 1 ? 5'h00 : 5'h1F);
		idle;
		$display("packet test done");
		// Downstream stall pushes back while a packet is mid-flight
		fork
			packet(4, 1'b1, 5'h03);
			begin
				@(posedge clk);
				out_ready <= 1'b0;
				repeat (6) @(posedge clk);
				out_ready <= 1'b1;
			end
		join
		idle;
		repeat (6) @(posedge clk);
		check(BW'(exp_q.size()), BW'(0));
		check(BW'(framing_error), BW'(0));
		check(BW'(busy), BW'(0));
		$display("stall test done");
		complete_run;
	end
endmodule
